/* File: include/vcpat_pkg.sv */
package vcpat_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] VC0_RESOURCE_CONTROL_OFFSET = 12'h0214;
  localparam logic [11:0] VC0_RESOURCE_STATUS_OFFSET = 12'h0218;
  localparam logic [11:0] VC0_ARB_TABLE_ENTRY_0_OFFSET = 12'h0240;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TABLE_LOAD_REQUEST_BIT = 16;
  localparam int TABLE_PENDING_FLAG_BIT = 17 - 1;
  localparam int NEGOTIATION_PENDING_FLAG_BIT = 17;
  localparam int PHASE_SLOT_WIDTH = 4;
  localparam int PHASE_SLOT_COUNT = 8;
  localparam int ARB_SCHEME_LSB = 17;
  localparam int ARB_SCHEME_MSB = 19;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [31:0] ARB_TABLE_ENTRY_0_RESET = 32'h0000_0000;
  localparam logic [2:0] ARB_SCHEME_RESET = 3'h0;
  localparam logic [3:0] PORT_CODE_MAX_LOW = 4'h9;
  localparam logic [3:0] PORT_CODE_12 = 4'hC;
  localparam logic [3:0] PORT_CODE_13 = 4'hD;
  localparam int PORT_COUNT = 14;
  // Scheme codes that use the table (time-based round robins)
  localparam logic [2:0] ARB_SCHEME_TABLE_MIN = 3'h3;

  typedef enum logic [2:0] {
    VCPAT_IDLE = 3'b001,
    VCPAT_LOAD = 3'b010,
    VCPAT_DONE = 3'b100
  } vcpat_load_state_t;
endpackage : vcpat_pkg

/* File: design/vcpat_top.sv */
`timescale 1ns/100ps
// What this block does
// RQ1 - Any software write to the table sets the table-pending flag.
// RQ2 - Flag stays set until hardware finishes loading after a load request.
// RQ3 - Flag meaningful only when the selected scheme uses the table.
// RQ4 - Negotiation-pending status bit always reads zero.
// RQ5 - Entry 0 holds eight RW 4-bit phase slots, reset zero.
// RQ6 - Slots naming invalid ports are skipped without spending a period.
// RQ7 - Software must not program reserved codes or the egress port itself.
// RQ8 - Codes 0-9 select ports 0-9, C port 12, D port 13; rest reserved.
// RQ9 - Writing one to load request starts a load; zero ignored; reads zero.
// RQ10 - Arbiter walks loaded slots ascending, one period each, wrapping to 0.
module vcpat_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] egress_port_id,
  input wire logic arb_period_done,
  output logic [3:0] grant_port,
  output logic grant_valid,
  output logic table_pending_flag,
  output logic table_in_use
);
  import vcpat_pkg::*;

  // ****************************************
  // Bus decode
  // ****************************************
  logic access;
  logic wr;
  logic hit_ctl;
  logic hit_sts;
  logic hit_tbl;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign hit_ctl = paddr == VC0_RESOURCE_CONTROL_OFFSET;
  assign hit_sts = paddr == VC0_RESOURCE_STATUS_OFFSET;
  assign hit_tbl = paddr == VC0_ARB_TABLE_ENTRY_0_OFFSET;
  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~(hit_ctl | hit_sts | hit_tbl);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [31:0] table_r;
  logic [31:0] table_nxt;
  logic [2:0] scheme_r;
  logic [2:0] scheme_nxt;
  logic table_wr;
  logic ctl_wr;
  logic load_req;

  assign table_wr = wr & hit_tbl;
  assign ctl_wr = wr & hit_ctl;
  // A zero in the request bit is simply ignored
  assign load_req = ctl_wr & pwdata[TABLE_LOAD_REQUEST_BIT]; // RQ9

  always_comb begin
    table_nxt = table_r;
    scheme_nxt = scheme_r;
    if (table_wr) begin
      table_nxt = pwdata; // RQ5
    end
    if (ctl_wr) begin
      scheme_nxt = pwdata[ARB_SCHEME_MSB:ARB_SCHEME_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_r <= ARB_TABLE_ENTRY_0_RESET;
      scheme_r <= ARB_SCHEME_RESET;
    end else begin
      table_r <= table_nxt;
      scheme_r <= scheme_nxt;
    end
  end

  // ****************************************
  // Load sequencer and pending flag
  // ****************************************
  logic [31:0] loaded_r;
  logic [31:0] loaded_nxt;
  logic pending_r;
  logic pending_nxt;
  vcpat_load_state_t state_r;
  vcpat_load_state_t state_nxt;

  always_comb begin
    loaded_nxt = loaded_r;
    pending_nxt = pending_r;
    state_nxt = state_r;
    case (state_r)
      VCPAT_IDLE: begin
        if (load_req) begin
          state_nxt = VCPAT_LOAD;
        end
      end
      VCPAT_LOAD: begin
        // Snapshot taken one cycle after request so same-cycle writes land
        loaded_nxt = table_r;
        state_nxt = VCPAT_DONE;
      end
      VCPAT_DONE: begin
        state_nxt = load_req ? VCPAT_LOAD : VCPAT_IDLE;
      end
      default: begin
        state_nxt = VCPAT_IDLE;
      end
    endcase
    // Set wins: a table write in the load cycle keeps the flag up
    if (state_r == VCPAT_LOAD) begin
      pending_nxt = 1'b0; // RQ2
    end
    if (table_wr) begin
      pending_nxt = 1'b1; // RQ1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_r <= ARB_TABLE_ENTRY_0_RESET;
      pending_r <= 1'b0;
      state_r <= VCPAT_IDLE;
    end else begin
      loaded_r <= loaded_nxt;
      pending_r <= pending_nxt;
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic rd_setup;

  // Captured in the setup cycle and held, so prdata stands all through access
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (rd_setup) begin
      if (hit_ctl) begin
        // Load request always reads back zero
        prdata_nxt[ARB_SCHEME_MSB:ARB_SCHEME_LSB] = scheme_r; // RQ9
      end else if (hit_sts) begin
        prdata_nxt[TABLE_PENDING_FLAG_BIT] = pending_r;
        prdata_nxt[NEGOTIATION_PENDING_FLAG_BIT] = 1'b0; // RQ4
      end else if (hit_tbl) begin
        prdata_nxt = table_r;
      end
    end else if (access) begin
      prdata_nxt = prdata_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // ****************************************
  // Status outputs
  // ****************************************
  assign table_in_use = scheme_r >= ARB_SCHEME_TABLE_MIN;
  // Flag is only meaningful while the table drives arbitration
  assign table_pending_flag = pending_r & table_in_use; // RQ3

  // ****************************************
  // Phase walker
  // ****************************************
  logic [PHASE_SLOT_COUNT-1:0] slot_ok;
  genvar g;
  generate
    for (g = 0; g < PHASE_SLOT_COUNT; g++) begin : g_slot
      logic [3:0] code;
      assign code = loaded_r[g*PHASE_SLOT_WIDTH +: PHASE_SLOT_WIDTH];
      // Egress port itself is illegal; treat like reserved and skip
      assign slot_ok[g] = ((code <= PORT_CODE_MAX_LOW) || (code == PORT_CODE_12) ||
                           (code == PORT_CODE_13)) && (code != egress_port_id); // RQ8 RQ7
    end
  endgenerate

  logic [2:0] phase_r;
  logic [2:0] phase_nxt;
  logic [2:0] cur;
  logic found;

  // Skip invalid slots combinationally so no period is spent on them
  always_comb begin
    cur = phase_r;
    found = 1'b0;
    for (int i = 0; i < PHASE_SLOT_COUNT; i++) begin
      if (!found && slot_ok[3'(int'(phase_r) + i)]) begin
        cur = 3'(int'(phase_r) + i); // RQ6
        found = 1'b1;
      end
    end
    phase_nxt = phase_r;
    if (state_r == VCPAT_LOAD) begin
      phase_nxt = 3'h0;
    end else if (found & arb_period_done) begin
      phase_nxt = cur + 3'h1; // RQ10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 3'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign grant_valid = found & table_in_use;
  assign grant_port = loaded_r[cur*PHASE_SLOT_WIDTH +: PHASE_SLOT_WIDTH]; // RQ10
endmodule : vcpat_top

/* File: verif/vcpat_properties.sv */
`timescale 1ns/100ps
module vcpat_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0] egress_port_id,
  input wire logic [3:0] grant_port,
  input wire logic arb_period_done,
  input wire logic grant_valid,
  input wire logic table_pending_flag,
  input wire logic table_in_use
);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire tw = acc && pwrite && paddr == 12'h0240;
  wire ld = acc && pwrite && paddr == 12'h0214 && pwdata[16];
  wire gok = grant_port <= 4'h9 || grant_port == 4'hC || grant_port == 4'hD;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pend_set: assert property (tw ##1 table_in_use |-> table_pending_flag)
    else $error("pending not set");
  a_pend_hold: assert property (table_in_use && $fell(table_pending_flag) |-> $past(ld, 2))
    else $error("pending dropped early");
  a_load_clr: assert property (ld ##1 !tw [*2] ##1 table_in_use |-> !table_pending_flag)
    else $error("pending not cleared");
  a_neg_zero: assert property (rd && paddr == 12'h0218 |-> !prdata[17])
    else $error("negotiation bit set");
  a_ld_read0: assert property (rd && paddr == 12'h0214 |-> !prdata[16])
    else $error("load bit reads one");
  a_grant_ok: assert property (grant_valid |-> gok && grant_port != egress_port_id)
    else $error("invalid port granted");
  a_scheme_gate: assert property (!table_in_use |-> !grant_valid && !table_pending_flag)
    else $error("table output without table scheme");
  a_grant_hold: assert property (
    !$past(arb_period_done) && !$past(ld, 2) && !$past(ld, 3) && $stable(egress_port_id)
    |-> $stable(grant_port)) else $error("grant moved without period end");
  c_load: cover property (ld);
  c_pend: cover property (tw ##1 table_pending_flag);
  c_step: cover property (arb_period_done && grant_valid);
endmodule : vcpat_properties
bind vcpat_top vcpat_properties props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .egress_port_id(egress_port_id), .grant_port(grant_port), .arb_period_done(arb_period_done),
  .grant_valid(grant_valid), .table_pending_flag(table_pending_flag), .table_in_use(table_in_use));

/* File: verif/vcpat_arb_model.sv */
`timescale 1ns/100ps
// Core stand-in; fast mode ends a period every cycle, back to back
module vcpat_arb_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic arb_go,
  input wire logic arb_fast,
  output logic arb_period_done
);
  logic done_nxt;
  always_comb done_nxt = arb_go && (arb_fast || !arb_period_done);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) arb_period_done <= 1'b0;
    else arb_period_done <= done_nxt;
  end
endmodule : vcpat_arb_model

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, arb_go = 0, arb_fast = 0, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, q, tbl, seed = 32'h0000_d131;
  logic [3:0] egress_port_id = '0;
  wire [31:0] prdata;
  wire [3:0] grant_port;
  wire pready, pslverr, arb_period_done, grant_valid, table_pending_flag, table_in_use;
  int n_fail = 0, cmp_count = 0, ph;
  vcpat_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .egress_port_id(egress_port_id), .arb_period_done(arb_period_done),
    .grant_port(grant_port), .grant_valid(grant_valid),
    .table_pending_flag(table_pending_flag), .table_in_use(table_in_use));
  vcpat_arb_model arb_u (.pclk(pclk), .presetn(presetn), .arb_go(arb_go), .arb_fast(arb_fast),
    .arb_period_done(arb_period_done));
  initial forever #2.5 pclk = ~pclk;
  function automatic logic [31:0] lf(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lf
  function automatic bit ok(input logic [3:0] c);
    return (c <= 4'h9 || c == 4'hC || c == 4'hD) && c != egress_port_id;
  endfunction : ok
  // First usable slot from a phase, or -1 when every slot is skipped
  function automatic int nxt(input int p);
    for (int j = 0; j < 8; j++) if (ok(tbl[4*((p+j)%8) +: 4])) return (p + j) % 8;
    return -1;
  endfunction : nxt
  // Software side of the table: no reserved code, never the egress port's own code
  function automatic logic [31:0] legal(input logic [31:0] v, input logic [3:0] own);
    logic [31:0] o;
    logic [3:0] c;
    o = v;
    for (int k = 0; k < 8; k++) begin
      c = v[4*k +: 4];
      if ((c > 4'h9 && c != 4'hC && c != 4'hD) || c == own) o[4*k +: 4] = (own == 4'h0) ? 4'h1 : 4'h0;
    end
    return o;
  endfunction : legal
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) n_fail++;
    if (pready !== 1'b1) give_verdict();
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h0218, 0); chk("status", 0, q);
    apb(0, 12'h0240, 0); chk("entry", 0, q);
    apb(0, 12'h0300, 0); chk("slverr", 1, e);
    for (int r = 0; r < 4; r++) begin
      seed = lf(seed);
      tbl = (r == 3) ? 32'hABEF_FABE : seed;
      // First passes keep the software rules; later ones exercise the skip choice
      if (r < 2) tbl = legal(tbl, seed[7:4]);
      egress_port_id <= seed[7:4];
      arb_fast <= r[0];
      apb(1, 12'h0214, 32'h0006_0000);
      apb(1, 12'h0240, tbl);
      apb(0, 12'h0240, 0); chk("entry", tbl, q);
      apb(0, 12'h0218, 0); chk("status", 32'h0001_0000, q);
      chk("pend pin", 1, table_pending_flag);
      chk("in use", 1, table_in_use);
      apb(1, 12'h0214, 32'h0007_0000);
      apb(0, 12'h0214, 0); chk("control", 32'h0006_0000, q);
      apb(0, 12'h0218, 0); chk("status", 0, q);
      ph = 0;
      arb_go <= 1'b1;
      repeat (20) begin
        @(posedge pclk);
        if (arb_period_done === 1'b1) ph = (nxt(ph) + 1) % 8;
        #1;
        chk("grant_valid", nxt(ph) >= 0, grant_valid);
        if (nxt(ph) >= 0) chk("grant_port", tbl[4*nxt(ph) +: 4], grant_port);
      end
      @(posedge pclk);
      arb_go <= 1'b0;
    end
    apb(1, 12'h0214, 0);
    apb(1, 12'h0240, tbl);
    chk("gated", 0, grant_valid);
    chk("pend gated", 0, table_pending_flag);
    chk("in use", 0, table_in_use);
    apb(0, 12'h0218, 0);
    chk("status", 32'h0001_0000, q);
    give_verdict();
  end
endmodule : tb_top
